// >>> logic/pscr_top.sv
`timescale 1ns/10ps
`include "pscr_defines.svh"
module pscr_top
   import pscr_pkg::*;
#(
   parameter logic [4:0] DWELL_LOG2_RST = `PSCR_DWELL_RST
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // sequencer requests and supply good flags
   input  wire logic        sleep_req,
   input  wire logic        wake_req,
   input  wire pscr_good_t  supply_good,
   // applied supply settings and converter controls
   output pscr_set_t        applied_set,
   output pscr_ctl_t        conv_ctl
);

   pscr_regs_t  r_reg;      // registered state
   pscr_regs_t  r_next;     // next state
   logic        req;        // address phase taken
   logic [31:0] lim;        // dwell end count of this state
   logic        dwell_done; // dwell expired
   logic        good_ok;    // every enabled supply good

   // reset image; the analog enable is pinned high
   localparam pscr_regs_t R_RST = '{
      st:      ST_RESET,
      cnt:     32'h0000_0000,
      applied: `PSCR_SET_RESET,
      prev:    `PSCR_PREV_RST,
      s2_log2: DWELL_LOG2_RST,
      s2:      `PSCR_SET_S2_RST,
      ctl:     '{pg_lvl:    `PSCR_PG_RST,
                 err_clr:   1'b0,
                 ilim_ana:  `PSCR_IL_RST,
                 clk_ana:   `PSCR_CK_RST,
                 ilim_core: `PSCR_IL_RST,
                 clk_core:  `PSCR_CK_RST},
      wsel:    SEL_NONE,
      hrdata:  32'h0000_0000,
      hready:  1'b1,
      hresp:   1'b0
   };

   // full-address decode, anything else maps to none
   function automatic pscr_sel_t dec(input logic [31:0] a);
      case (a)
         `PSCR_OFF_S2:   dec = SEL_S2;
         `PSCR_OFF_STAT: dec = SEL_STAT;
         `PSCR_OFF_CTL:  dec = SEL_CTL;
         default:        dec = SEL_NONE;
      endcase
   endfunction

   // place settings at their word positions, rest zero
   function automatic logic [31:0] set_word(input pscr_set_t s);
      set_word = 32'h0000_0000;
      set_word[`PSCR_B_CLKOFF] = s.clk_off;
      set_word[`PSCR_B_MODA] = s.mod_ana;
      set_word[`PSCR_B_MODC] = s.mod_core;
      set_word[`PSCR_B_IO] = s.io_en;
      set_word[`PSCR_B_PLL] = s.pll_en;
      set_word[`PSCR_B_ANA] = s.ana_en;
      set_word[`PSCR_B_CORE] = s.core_en;
   endfunction

   // settings applied in a state; only sleep stage two is programmable
   function automatic pscr_set_t set_of(input pscr_seq_t st,
                                        input pscr_set_t s2);
      case (st)
         ST_RESET:  set_of = `PSCR_SET_RESET;
         ST_ASLEEP: set_of = `PSCR_SET_ASLEEP;
         ST_WAKE1:  set_of = `PSCR_SET_WAKE1;
         ST_WAKE2:  set_of = `PSCR_SET_WAKE2;
         ST_AWAIT:  set_of = `PSCR_SET_AWAKE;
         ST_AWAKE:  set_of = `PSCR_SET_AWAKE;
         ST_SLEEP1: set_of = `PSCR_SET_SLEEP1;
         ST_SLEEP2: set_of = s2;                  // see [RULE2]
         default:   set_of = `PSCR_SET_RESET;
      endcase
   endfunction

   // enables of a settings word, one flag per supply
   function automatic pscr_good_t en_of(input pscr_set_t s);
      en_of = '{io: s.io_en, pll: s.pll_en, ana: s.ana_en, core: s.core_en};
   endfunction

   // read mux; status reflects the state of the data phase
   function automatic logic [31:0] rd_word(input pscr_sel_t sel,
                                           input pscr_regs_t q);
      rd_word = 32'h0000_0000;                      // see [RULE19]
      case (sel)
         SEL_S2: begin
            rd_word = set_word(q.s2);
            rd_word[`PSCR_B_ANA] = 1'b1;               // see [RULE7]
            rd_word[`PSCR_B_DWELL_HI:`PSCR_B_DWELL_LO] = q.s2_log2;
         end
         SEL_STAT: begin
            rd_word = set_word(q.applied);             // see [RULE11]
            rd_word[`PSCR_B_ST_HI:`PSCR_B_ST_LO] = q.st;  // see [RULE9]
            rd_word[`PSCR_B_PIO] = q.prev.io;          // see [RULE10]
            rd_word[`PSCR_B_PPLL] = q.prev.pll;
            rd_word[`PSCR_B_PANA] = q.prev.ana;
            rd_word[`PSCR_B_PCORE] = q.prev.core;
         end
         SEL_CTL: begin
            rd_word[`PSCR_B_PG_HI:`PSCR_B_PG_LO] = q.ctl.pg_lvl;
            rd_word[`PSCR_B_ERRCLR] = q.ctl.err_clr;
            rd_word[`PSCR_B_ILA_HI:`PSCR_B_ILA_LO] = q.ctl.ilim_ana;
            rd_word[`PSCR_B_CKA_HI:`PSCR_B_CKA_LO] = q.ctl.clk_ana;
            rd_word[`PSCR_B_ILC_HI:`PSCR_B_ILC_LO] = q.ctl.ilim_core;
            rd_word[`PSCR_B_CKC_HI:`PSCR_B_CKC_LO] = q.ctl.clk_core;
         end
         default: begin
            rd_word = 32'h0000_0000;                   // unmapped reads zero
         end
      endcase
   endfunction

   // dwell limit and supply-good check for the current state
   always_comb begin
      if (r_reg.st == ST_SLEEP2) begin
         lim = (32'h0000_0001 << r_reg.s2_log2) - 32'h0000_0001;  // see [RULE1]
      end else begin
         lim = (32'h0000_0001 << DWELL_LOG2_RST) - 32'h0000_0001;
      end
      dwell_done = (r_reg.cnt == lim);
      good_ok = ((supply_good & en_of(r_reg.applied)) ==
                 en_of(r_reg.applied));
      req = hsel && htrans[1] && hready;
   end

   // next state: bus write, sequencer, applied settings, bus read
   always_comb begin
      r_next = r_reg;
      r_next.hready = 1'b1;          // zero wait states
      r_next.hresp = 1'b0;           // always okay
      // write data phase; status and unmapped writes are dropped
      case (r_reg.wsel)
         SEL_S2: begin
            r_next.s2_log2 = hwdata[`PSCR_B_DWELL_HI:`PSCR_B_DWELL_LO];
            r_next.s2.clk_off = hwdata[`PSCR_B_CLKOFF];   // see [RULE2]
            r_next.s2.mod_ana = hwdata[`PSCR_B_MODA];     // see [RULE3]
            r_next.s2.mod_core = hwdata[`PSCR_B_MODC];    // see [RULE4]
            r_next.s2.io_en = hwdata[`PSCR_B_IO];         // see [RULE5]
            r_next.s2.pll_en = hwdata[`PSCR_B_PLL];       // see [RULE6]
            r_next.s2.ana_en = 1'b1;                      // see [RULE7]
            r_next.s2.core_en = hwdata[`PSCR_B_CORE];     // see [RULE8]
         end
         SEL_CTL: begin
            r_next.ctl.pg_lvl = hwdata[`PSCR_B_PG_HI:`PSCR_B_PG_LO];  // see [RULE12]
            r_next.ctl.err_clr = hwdata[`PSCR_B_ERRCLR];   // see [RULE13]
            r_next.ctl.ilim_ana = hwdata[`PSCR_B_ILA_HI:`PSCR_B_ILA_LO];  // see [RULE14]
            r_next.ctl.clk_ana = hwdata[`PSCR_B_CKA_HI:`PSCR_B_CKA_LO];   // see [RULE15]
            r_next.ctl.ilim_core = hwdata[`PSCR_B_ILC_HI:`PSCR_B_ILC_LO]; // see [RULE16]
            r_next.ctl.clk_core = hwdata[`PSCR_B_CKC_HI:`PSCR_B_CKC_LO];  // see [RULE17]
         end
         default: begin
            r_next.wsel = SEL_NONE;
         end
      endcase
      r_next.wsel = SEL_NONE;
      // sequencer transitions
      case (r_reg.st)
         ST_RESET: begin
            r_next.st = ST_WAKE1;
         end
         ST_ASLEEP: begin
            if (wake_req) begin
               r_next.st = ST_WAKE1;
            end
         end
         ST_WAKE1: begin
            if (dwell_done && good_ok) begin     // see [RULE18]
               r_next.st = ST_WAKE2;
            end
         end
         ST_WAKE2: begin
            if (dwell_done && good_ok) begin     // see [RULE18]
               r_next.st = ST_AWAIT;
            end
         end
         ST_AWAIT: begin
            if (good_ok) begin
               r_next.st = ST_AWAKE;
            end
         end
         ST_AWAKE: begin
            if (sleep_req) begin
               r_next.st = ST_SLEEP1;
            end
         end
         ST_SLEEP1: begin
            if (dwell_done) begin
               r_next.st = ST_SLEEP2;
            end
         end
         ST_SLEEP2: begin
            if (dwell_done) begin                // see [RULE1]
               r_next.st = ST_ASLEEP;
            end
         end
         default: begin
            r_next.st = ST_RESET;
         end
      endcase
      // dwell counter restarts on every entry; wide so N=31 fits
      if (r_next.st != r_reg.st) begin
         r_next.cnt = 32'h0000_0000;
         r_next.prev = en_of(r_reg.applied);    // see [RULE10]
      end else if (!dwell_done) begin
         r_next.cnt = r_reg.cnt + 32'h0000_0001;
      end
      // settings follow the state they belong to, same edge
      r_next.applied = set_of(r_next.st, r_next.s2);
      // address phase: writes land next cycle, reads answer next cycle
      if (req) begin
         if (hwrite) begin
            r_next.wsel = dec(haddr);
         end else begin
            r_next.hrdata = rd_word(dec(haddr), r_next);
         end
      end
   end

   // one register for the whole block
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         r_reg <= R_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state flops
   assign hreadyout = r_reg.hready;
   assign hresp = r_reg.hresp;
   assign hrdata = r_reg.hrdata;
   assign applied_set = r_reg.applied;
   assign conv_ctl = r_reg.ctl;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // dwell not yet over keeps the second sleep stage
   property p_s2_hold;
      (r_reg.st == ST_SLEEP2 && r_reg.cnt < lim) |=> r_reg.st == ST_SLEEP2;
   endproperty
   a_s2_hold: assert property (p_s2_hold) else $error("left sleep2 early"); // see [RULE1]

   // dwell over leaves for asleep
   property p_s2_exit;
      (r_reg.st == ST_SLEEP2 && r_reg.cnt == lim) |=> r_reg.st == ST_ASLEEP;
   endproperty
   a_s2_exit: assert property (p_s2_exit) else $error("sleep2 overstayed"); // see [RULE1]

   // clock gate and modulation follow the sleep2 settings
   property p_s2_clkmod;
      (r_reg.st == ST_SLEEP2) |-> (applied_set.clk_off == r_reg.s2.clk_off &&
         applied_set.mod_ana == r_reg.s2.mod_ana &&
         applied_set.mod_core == r_reg.s2.mod_core);
   endproperty
   a_s2_clkmod: assert property (p_s2_clkmod) else $error("clk/mod wrong"); // see [RULE2]

   // supply enables in sleep2, analog always on
   property p_s2_en;
      (r_reg.st == ST_SLEEP2) |-> (applied_set.ana_en &&
         applied_set.core_en == r_reg.s2.core_en &&
         applied_set.io_en == r_reg.s2.io_en &&
         applied_set.pll_en == r_reg.s2.pll_en);
   endproperty
   a_s2_en: assert property (p_s2_en) else $error("sleep2 enables wrong"); // see [RULE8]

   // status read returns state, applied clock-off and core enable, zero in bits 31:30 and 23:19
   property p_stat;
      (req && !hwrite && haddr == `PSCR_OFF_STAT) |=>
         (hrdata[`PSCR_B_ST_HI:`PSCR_B_ST_LO] == r_reg.st &&
          hrdata[`PSCR_B_CLKOFF] == applied_set.clk_off &&
          hrdata[`PSCR_B_CORE] == applied_set.core_en &&
          hrdata[31:30] == 2'h0 && hrdata[23:19] == 5'h00);
   endproperty
   a_stat: assert property (p_stat) else $error("status word wrong"); // see [RULE9]

   // previous enables captured at each state change
   property p_prev;
      (r_reg.st != $past(r_reg.st)) |->
         (r_reg.prev.io == $past(r_reg.applied.io_en) &&
          r_reg.prev.core == $past(r_reg.applied.core_en));
   endproperty
   a_prev: assert property (p_prev) else $error("previous enables wrong"); // see [RULE10]

   // error clear and control fields follow a write one cycle on
   property p_ctl;
      (req && hwrite && haddr == `PSCR_OFF_CTL) ##1 1'b1 |=>
         (conv_ctl.err_clr == $past(hwdata[`PSCR_B_ERRCLR]) &&
          conv_ctl.pg_lvl == $past(hwdata[`PSCR_B_PG_HI:`PSCR_B_PG_LO]) &&
          conv_ctl.clk_core == $past(hwdata[`PSCR_B_CKC_HI:`PSCR_B_CKC_LO]));
   endproperty
   a_ctl: assert property (p_ctl) else $error("control write lost"); // see [RULE13]

   // waking stage two waits for its supplies
   property p_wake;
      (r_reg.st == ST_WAKE2 && !good_ok) |=> r_reg.st == ST_WAKE2;
   endproperty
   a_wake: assert property (p_wake) else $error("woke with bad supply"); // see [RULE18]

   // waking stage one holds until its dwell is over and its supplies are good
   property p_wake1;
      (r_reg.st == ST_WAKE1 && (r_reg.cnt < lim || !good_ok)) |=> r_reg.st == ST_WAKE1;
   endproperty
   a_wake1: assert property (p_wake1) else $error("left waking one early"); // see [RULE18]

   // only the programmable sleep stage may stop the tile clock
   property p_clk_gate;
      (r_reg.st != ST_SLEEP2) |-> !applied_set.clk_off;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("tile clock gated"); // see [RULE2]

   // settings read keeps reserved bits zero and the analog enable high
   property p_s2_rd;
      (req && !hwrite && haddr == `PSCR_OFF_S2) |=>
         ((hrdata & `PSCR_RSV_S2) == 32'h0000_0000 && hrdata[`PSCR_B_ANA]);
   endproperty
   a_s2_rd: assert property (p_s2_rd) else $error("settings read wrong"); // see [RULE19]

   // control read keeps reserved bits zero
   property p_ctl_rd;
      (req && !hwrite && haddr == `PSCR_OFF_CTL) |=>
         ((hrdata & `PSCR_RSV_CTL) == 32'h0000_0000);
   endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong"); // see [RULE19]

endmodule

// >>> logic/pscr_defines.svh
// Overview of operation
// [RULE1] second sleep dwell is two to the N cycles
// [RULE2] clock-off bit gates processor tile clock
// [RULE3] bit 9 picks analog converter modulation
// [RULE4] bit 8 picks core converter modulation
// [RULE5] bit 5 enables io supply output
// [RULE6] bit 4 enables pll linear regulator
// [RULE7] analog converter enable reads one, unwritable
// [RULE8] bit 0 enables core converter, resets off
// [RULE9] status bits 18:16 show sequencer state
// [RULE10] status shows previous state's supply enables
// [RULE11] status mirrors currently applied settings
// [RULE12] bits 25:24 set power-good threshold
// [RULE13] error flags held clear while bit set
// [RULE14] bits 14:13 set analog current limit
// [RULE15] bits 9:8 set analog switching clock
// [RULE16] bits 6:5 set core current limit
// [RULE17] bits 1:0 set core switching clock
// [RULE18] waking moves on after dwell and supplies good
// [RULE19] reserved bits read zero, ignore writes
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH
// register byte addresses
`define PSCR_OFF_S2      32'h0000_0020
`define PSCR_OFF_STAT    32'h0000_0024
`define PSCR_OFF_CTL     32'h0000_002c
// per-state settings bit positions
`define PSCR_B_DWELL_HI  20
`define PSCR_B_DWELL_LO  16
`define PSCR_B_CLKOFF    14
`define PSCR_B_MODA      9
`define PSCR_B_MODC      8
`define PSCR_B_IO        5
`define PSCR_B_PLL       4
`define PSCR_B_ANA       1
`define PSCR_B_CORE      0
// status positions
`define PSCR_B_ST_HI     18
`define PSCR_B_ST_LO     16
`define PSCR_B_PIO       29
`define PSCR_B_PPLL      28
`define PSCR_B_PANA      25
`define PSCR_B_PCORE     24
// converter control positions
`define PSCR_B_PG_HI     25
`define PSCR_B_PG_LO     24
`define PSCR_B_ERRCLR    16
`define PSCR_B_ILA_HI    14
`define PSCR_B_ILA_LO    13
`define PSCR_B_CKA_HI    9
`define PSCR_B_CKA_LO    8
`define PSCR_B_ILC_HI    6
`define PSCR_B_ILC_LO    5
`define PSCR_B_CKC_HI    1
`define PSCR_B_CKC_LO    0
// reset values
`define PSCR_DWELL_RST   5'h10
`define PSCR_PG_RST      2'h2
`define PSCR_CK_RST      2'h1
`define PSCR_IL_RST      2'h0
`define PSCR_PREV_RST    4'h2
// reserved bits of the settings and control words, read as zero
`define PSCR_RSV_S2      32'hffe0_bccc
`define PSCR_RSV_CTL     32'hfcfe_9c9c
// fixed settings of the other states and the sleep2 reset settings, {clk,moda,modc,io,pll,ana,core}
`define PSCR_SET_RESET   7'h02
`define PSCR_SET_ASLEEP  7'h02
`define PSCR_SET_WAKE1   7'h0c
`define PSCR_SET_WAKE2   7'h0f
`define PSCR_SET_AWAKE   7'h0f
`define PSCR_SET_SLEEP1  7'h0a
`define PSCR_SET_S2_RST  7'h02
`endif

// >>> logic/pscr_pkg.sv
package pscr_pkg;
   // settings applied by the sequencer in one state
   typedef struct packed {
      logic clk_off;    // gate processor tile clock
      logic mod_ana;    // analog converter pfm
      logic mod_core;   // core converter pfm
      logic io_en;      // io supply output on
      logic pll_en;     // pll linear regulator on
      logic ana_en;     // analog converter on
      logic core_en;    // core converter on
   } pscr_set_t;
   // one flag per supply
   typedef struct packed {
      logic io;
      logic pll;
      logic ana;
      logic core;
   } pscr_good_t;
   // converter control fields
   typedef struct packed {
      logic [1:0] pg_lvl;
      logic       err_clr;
      logic [1:0] ilim_ana;
      logic [1:0] clk_ana;
      logic [1:0] ilim_core;
      logic [1:0] clk_core;
   } pscr_ctl_t;
   // sequencer states, codes as reported in status
   typedef enum logic [2:0] {
      ST_RESET  = 3'b000,
      ST_ASLEEP = 3'b001,
      ST_WAKE1  = 3'b010,
      ST_WAKE2  = 3'b011,
      ST_AWAIT  = 3'b100,
      ST_AWAKE  = 3'b101,
      ST_SLEEP1 = 3'b110,
      ST_SLEEP2 = 3'b111
   } pscr_seq_t;
   // register select from address decode
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_S2   = 2'b01,
      SEL_STAT = 2'b10,
      SEL_CTL  = 2'b11
   } pscr_sel_t;
   // all state of the block
   typedef struct packed {
      pscr_seq_t   st;
      logic [31:0] cnt;
      pscr_set_t   applied;
      pscr_good_t  prev;
      logic [4:0]  s2_log2;
      pscr_set_t   s2;
      pscr_ctl_t   ctl;
      pscr_sel_t   wsel;
      logic [31:0] hrdata;
      logic        hready;
      logic        hresp;
   } pscr_regs_t;
endpackage

// >>> dv/pscr_supply_model.sv
`timescale 1ns/10ps
module pscr_supply_model
   import pscr_pkg::*;
#(
   parameter int RISE_DLY = 3   // cycles from enable to good
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire pscr_set_t  applied_set,
   input  wire logic       hold,
   output pscr_good_t      supply_good
);
   logic [3:0] en_now;    // enables as the sequencer applies them
   logic [3:0] en_last;   // enables one cycle ago
   int         settle;    // cycles since the enables last changed

   assign en_now = {applied_set.io_en, applied_set.pll_en, applied_set.ana_en,
                    applied_set.core_en};

   // any change of enables restarts the ramp of every supply
   always @(posedge sys_clk) begin
      en_last <= en_now;
      if (!rstn || en_now != en_last) begin
         settle <= 0;
      end else if (settle < RISE_DLY) begin
         settle <= settle + 1;
      end
   end

   // a disabled supply reads not good; hold keeps every rail low to stall waking
   assign supply_good = (hold || settle < RISE_DLY) ? pscr_good_t'(4'h0)
                                                    : pscr_good_t'(en_now);
endmodule

// >>> dv/power_sequence_ctrl_regs_tb_top.sv
`timescale 1ns/10ps
module power_sequence_ctrl_regs_tb_top
   import pscr_pkg::*;
;
   localparam logic [4:0] N_RST = 5'h2;   // short dwell keeps the run brief
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        sleep_req = 1'b0;
   logic        wake_req = 1'b0;
   logic        hold = 1'b1;         // stalls the supplies at start
   pscr_good_t  supply_good;
   pscr_set_t   applied_set;
   pscr_ctl_t   conv_ctl;
   pscr_set_t   watch = 7'h00;      // settings pattern being timed
   int          run_cnt = 0;        // cycles the watched pattern stood
   int          n_fail = 0;
   int          n_tests = 0;
   logic [31:0] rd;

   always #12.5 sys_clk = ~sys_clk;

   pscr_top #(.DWELL_LOG2_RST(N_RST)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
      .wake_req(wake_req), .supply_good(supply_good), .applied_set(applied_set),
      .conv_ctl(conv_ctl));

   pscr_supply_model #(.RISE_DLY(3)) supplies (
      .sys_clk(sys_clk), .rstn(rstn), .applied_set(applied_set), .hold(hold),
      .supply_good(supply_good));

   // dwell counter sampled at the same edges the design uses
   always @(posedge sys_clk) begin
      if (applied_set === watch) begin
         run_cnt <= run_cnt + 1;
      end
   end

   task automatic summarize();
      $display("counts: tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask

   // wait for hready at a rising edge; a hung slave ends the run
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 100);
      if (k >= 100) begin
         n_fail++;
         summarize();
      end
   endtask

   // one single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, rd);
      chk(rd, exp);
      chk(32'(hresp), 32'h0);                        // slave always answers okay
   endtask

   // bounded wait until the sequencer applies a given pattern
   task automatic wait_set(input pscr_set_t pat);
      int k;
      for (k = 0; k < 500 && applied_set !== pat; k++) begin
         @(posedge sys_clk);
      end
      if (applied_set !== pat) begin
         n_fail++;
         summarize();
      end
   endtask

   // reset values, read-only and reserved bits of the settings register
   task automatic t_sleep_regs();
      rd_chk(32'h20, {11'h0, N_RST, 16'h0002});
      rd_chk(32'h28, 32'h0);
      wr(32'h20, 32'hffff_ffff);
      rd_chk(32'h20, 32'h001f_4333);
      wr(32'h20, 32'h0);
      rd_chk(32'h20, 32'h0000_0002);
      $display("test sleep_regs done");
   endtask

   // every code of every converter field, then the error clear level
   task automatic t_conv_ctl();
      logic [31:0] d;
      logic [31:0] e;
      chk(32'(conv_ctl), 32'h411);
      rd_chk(32'h2c, 32'h0200_0101);
      for (int c = 0; c < 4; c++) begin
         d = (c << 24) | (c << 13) | (c << 8) | (c << 5) | c;
         wr(32'h2c, d | 32'hfcfe_9c9c);              // reserved bits set too
         @(posedge sys_clk);
         #1;
         e = 32'({c[1:0], 1'b0, c[1:0], c[1:0], c[1:0], c[1:0]});
         chk(32'(conv_ctl), e);
         rd_chk(32'h2c, d);
      end
      wr(32'h2c, 32'h0201_0101);
      repeat (20) @(posedge sys_clk);
      chk(32'(conv_ctl.err_clr), 32'h1);
      wr(32'h2c, 32'h0200_0101);
      @(posedge sys_clk);
      #1;
      chk(32'(conv_ctl), 32'h411);
      $display("test conv_ctl done");
   endtask

   // waking stalls while supplies are not good, then reaches awake
   task automatic t_wake();
      chk(32'(applied_set), 32'h0c);
      hold <= 1'b0;
      wait_set(7'h0f);
      repeat (30) @(posedge sys_clk);
      rd_chk(32'h24, 32'h3305_0033);
      $display("test wake done");
   endtask

   // one trip through the sleep stages with programmed settings and dwell
   task automatic t_sleep(input logic [4:0] n, input logic [31:0] s2, input pscr_set_t pat,
                          input logic [31:0] stat_exp);
      int base;
      wr(32'h20, s2);
      watch = pat;
      base  = run_cnt;                               // counter has one driver only
      sleep_req <= 1'b1;
      wait_set(pat);
      chk(32'(applied_set), 32'(pat));
      sleep_req <= 1'b0;
      if (stat_exp != 32'h0) begin
         rd_chk(32'h24, stat_exp);
      end
      wait_set(7'h02);
      chk(32'(run_cnt - base), 32'h1 << n);
      wake_req <= 1'b1;
      wait_set(7'h0f);
      wake_req <= 1'b0;
      $display("test sleep n=%0d done", n);
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_sleep_regs();
      t_conv_ctl();
      t_wake();
      t_sleep(5'h2, 32'h0002_4331, 7'h7f, 32'h0);
      t_sleep(5'h3, 32'h0003_0201, 7'h23, 32'h2207_0203);
      summarize();
   end
endmodule
